/* File: hw/dbw_mode_regs.sv */
// Mode register fields for latency, postamble and burst length.
`timescale 1ns/1ps
`include "dbw_defines.svh"
module dbw_mode_regs
   import dbw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       mrw_valid,
   input  wire logic [5:0] mrw_addr,
   input  wire logic [7:0] mrw_op,
   dbw_link_if.mode        lnk
);

   dbw_mode_t r;        // Registered fields.
   dbw_mode_t next_r;   // Next fields.

   // Picks the latency from the selected set and frequency index.
   function automatic logic [5:0] wl_lookup(input logic [2:0] idx,
                                            input logic       setb);
      logic [47:0] tbl;
      tbl = setb ? `DBW_WL_SET_B : `DBW_WL_SET_A;
      wl_lookup = tbl[idx * 6 +: 6];
   endfunction : wl_lookup

   // Fields change only on a mode register write to their address.
   always_comb
   begin
      next_r = r;
      if (mrw_valid)
      begin
         unique case (mrw_addr)
            `DBW_MR_BL_ADDR:
               next_r.bl32 = mrw_op[`DBW_MR_BL_BIT];
            `DBW_MR_WL_ADDR:
            begin
               next_r.wl_idx  = mrw_op[`DBW_MR_WL_IDX_HI:`DBW_MR_WL_IDX_LO];
               next_r.wl_setb = mrw_op[`DBW_MR_WL_SET_BIT];
            end
            `DBW_MR_PST_ADDR:
               next_r.post_ext = mrw_op[`DBW_MR_PST_BIT];
            // Other addresses belong to other blocks.
            default:
               next_r = r;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end

   assign lnk.wl_value = wl_lookup(r.wl_idx, r.wl_setb);
   assign lnk.post_ext = r.post_ext;
   assign lnk.bl32     = r.bl32;

endmodule : dbw_mode_regs

/* File: hw/dbw_pin_sync.sv */
// Two-stage synchroniser and edge finder for the link pins.
`timescale 1ns/1ps
`include "dbw_defines.svh"
module dbw_pin_sync
   import dbw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       ck_pin,
   input  wire logic       cs_pin,
   input  wire logic [5:0] ca_pin,
   input  wire logic       strb_t_pin,
   input  wire logic [7:0] dq_pin,
   dbw_link_if.sync        lnk
);

   dbw_sync_t r;        // Registered state.
   dbw_sync_t next_r;   // Next state.

   // All pins travel together so that command and data stay aligned with
   // the clock and strobe edges found from the same second stage.
   always_comb
   begin
      next_r       = r;
      next_r.s1    = {ck_pin, cs_pin, ca_pin, strb_t_pin, dq_pin};
      next_r.s2    = r.s1;
      next_r.ck3   = r.s2[`DBW_PIN_CK];
      next_r.strb3 = r.s2[`DBW_PIN_STRB];
   end

   // Only the second stage reads the first; edges use stages two and three.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end

   // Edge pulses and aligned levels for the core.
   assign lnk.ck_rise   = r.s2[`DBW_PIN_CK] & ~r.ck3;
   assign lnk.strb_rise = r.s2[`DBW_PIN_STRB] & ~r.strb3;
   assign lnk.strb_fall = ~r.s2[`DBW_PIN_STRB] & r.strb3;
   assign lnk.cs        = r.s2[`DBW_PIN_CS];
   assign lnk.ca        = r.s2[`DBW_PIN_CA_HI:`DBW_PIN_CA_LO];
   assign lnk.dq        = r.s2[`DBW_PIN_DQ_HI:0];

endmodule : dbw_pin_sync

/* File: hw/dbw_write_path.sv */
// Write-burst data path of the memory device: command to captured beats.
`timescale 1ns/1ps
`include "dbw_defines.svh"
module dbw_write_path
   import dbw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       ck_pin,
   input  wire logic       cs_pin,
   input  wire logic [5:0] ca_pin,
   input  wire logic       strb_t_pin,
   input  wire logic [7:0] dq_pin,
   input  wire logic       mrw_valid,
   input  wire logic [5:0] mrw_addr,
   input  wire logic [7:0] mrw_op,
   output logic            burst_start,
   output logic [9:0]      burst_column,
   output logic            beat_valid,
   output logic [7:0]      beat_data,
   output logic [4:0]      beat_index,
   output logic            burst_last,
   output logic            recovery_start,
   output logic            align_error,
   output logic            preamble_window,
   output logic            busy
);

   // Pin events and mode fields shared by the three modules.
   dbw_link_if lnk ();

   // Timing model, in sys_clk cycles. Every pin passes the same two
   // flip-flops, so a command clock edge, a strobe edge and the data
   // beside them reach the logic together, some cycles after the pins.
   // The block only orders pin edges against each other and never
   // against sys_clk itself. The price is that a strobe half period
   // must span more than one sys_clk cycle, or two strobe edges
   // would fold into one sampled level and a beat would be lost.

   dbw_core_t r;        // Registered sequencer state and outputs.
   dbw_core_t next_r;   // Next sequencer state.

   logic [5:0] next_lat;     // Latency count after this clock edge.
   logic [5:0] pre_start;    // Latency count that opens the preamble.
   logic [4:0] last_beat;    // Index of the final beat of the burst.
   logic [1:0] post_edges;   // Strobe half periods of the postamble.
   logic       strb_edge;    // Any strobe transition this cycle.
   logic       is_cmd;       // Select high on a command clock edge.

   // Synchronises every link pin and finds the clock and strobe edges.
   // It stays a module of its own so its flops can sit near the pins
   // and carry no other logic.
   dbw_pin_sync u_sync (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .ck_pin     (ck_pin),
      .cs_pin     (cs_pin),
      .ca_pin     (ca_pin),
      .strb_t_pin (strb_t_pin),
      .dq_pin     (dq_pin),
      .lnk        (lnk.sync)
   );

   // Holds the mode fields written through the mode register path.
   // Mode writes come on sys_clk already, so they need no synchroniser;
   // a new value reaches a burst only at its column half.
   dbw_mode_regs u_mode (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .mrw_valid (mrw_valid),
      .mrw_addr  (mrw_addr),
      .mrw_op    (mrw_op),
      .lnk       (lnk.mode)
   );

   // Derived values; the burst uses the settings latched at its command so
   // that a mode write during a burst cannot cut it short.
   // post_edges counts strobe half periods: one for the short postamble,
   // three for the extended one that adds a whole strobe cycle.
   always_comb
   begin
      next_lat   = r.lat_cnt + 6'h01;
      pre_start  = r.wl - `DBW_WPRE_NCK;
      last_beat  = r.bl32 ? `DBW_BEAT_LAST_32 : `DBW_BEAT_LAST_16;
      post_edges = r.ext ? `DBW_WPST_HALF_EXT : `DBW_WPST_HALF_STD;
      strb_edge  = lnk.strb_rise | lnk.strb_fall;
      is_cmd     = lnk.ck_rise & lnk.cs;
   end

   // Walk of one burst. The write half arrives on one command clock rise
   // and the column half on the next; any other pair is thrown away.
   // From the column half the latency counter counts clock rises. Two
   // rises before it runs out the preamble window opens, and at the last
   // rise the capture is armed. The first true-strobe rise after that is
   // beat 0, and every later strobe edge carries one more beat. After
   // the final beat the postamble edges are swallowed, so that they are
   // never taken for the first beat of a following burst.
   // The recovery pulse sits outside the state machine because its clock
   // rise may come after a short postamble has already ended.
   //
   // Sequencer: decode, latency count, capture and postamble.
   always_comb
   begin
      next_r             = r;
      next_r.burst_start = 1'b0;
      next_r.beat_valid  = 1'b0;
      next_r.burst_last  = 1'b0;
      next_r.rec_start   = 1'b0;
      next_r.align_err   = 1'b0;

      if (r.rec_pend && lnk.ck_rise)
      begin
         next_r.rec_pend  = 1'b0;
         next_r.rec_start = 1'b1;
      end

      unique case (r.state)
         // Waits for the first half of a write command.
         // Commands are only looked at here, so one sent while busy is
         // lost; the controller must wait for the burst to end.
         ST_IDLE:
         begin
            if (is_cmd && lnk.ca[4:0] == `DBW_CMD_WRITE1)
            begin
               next_r.state = ST_CAS;
               // column bit three must be low
               next_r.align_err = lnk.ca[5];
            end
         end

         // The column half must follow on the very next clock edge.
         // Column bits three to zero are not carried and are reported as zero.
         ST_CAS:
         begin
            if (lnk.ck_rise)
            begin
               if (lnk.cs && lnk.ca[4:0] == `DBW_CMD_CAS2)
               begin
                  next_r.column      = {lnk.ca, 4'h0};
                  next_r.burst_start = 1'b1;
                  next_r.lat_cnt     = 6'h00;
                  next_r.wl          = lnk.wl_value;
                  next_r.bl32        = lnk.bl32;
                  next_r.ext         = lnk.post_ext;
                  next_r.state       = ST_LATENCY;
               end
               else
               begin
                  // A broken pair is dropped rather than guessed at.
                  next_r.state = ST_IDLE;
               end
            end
         end

         // Counts clock edges; the strobe is not looked at yet.
         // The latency was latched at the column half, so a mode write in
         // the meantime can neither shorten nor stretch this count.
         ST_LATENCY:
         begin
            if (lnk.ck_rise)
            begin
               next_r.lat_cnt = next_lat;
               if (next_lat == pre_start)
                  next_r.state = ST_PREAMBLE;
            end
         end

         // Preamble window: strobe toggles here carry no data.
         ST_PREAMBLE:
         begin
            if (lnk.ck_rise)
            begin
               next_r.lat_cnt = next_lat;
               // latching edge follows the latency edge
               if (next_lat == r.wl)
                  next_r.state = ST_ARMED;
            end
         end

         // Waits for the first latching rise of the true strobe.
         // A strobe that never rises leaves the sequencer here; that edge
         // is owed by the controller and is not timed out.
         ST_ARMED:
         begin
            // first latching edge is a rise
            if (lnk.strb_rise)
            begin
               next_r.beat_valid = 1'b1;
               next_r.beat_data  = lnk.dq;
               next_r.beat_index = 5'h00;
               next_r.beat_cnt   = 5'h01;
               next_r.state      = ST_CAPTURE;
            end
         end

         // Each further strobe edge carries one beat.
         // Data is taken from the same stage as its edge, so the two
         // cannot slip apart by a cycle.
         ST_CAPTURE:
         begin
            if (strb_edge)
            begin
               next_r.beat_valid = 1'b1;
               next_r.beat_data  = lnk.dq;
               next_r.beat_index = r.beat_cnt;
               next_r.beat_cnt   = r.beat_cnt + 5'h01;
               if (r.beat_cnt == last_beat)
               begin
                  next_r.burst_last = 1'b1;
                  next_r.rec_pend   = 1'b1;
                  next_r.post_cnt   = 2'h0;
                  next_r.post_ck    = 2'h0;
                  next_r.state      = ST_POST;
               end
            end
         end

         // Postamble: strobe edges are swallowed until it has run out.
         // The strobe count and the clock count may both end it; whichever
         // comes first wins, and both lead to the same idle state.
         ST_POST:
         begin
            // half or one and a half clocks
            if (strb_edge)
            begin
               next_r.post_cnt = r.post_cnt + 2'h1;
               if (r.post_cnt + 2'h1 == post_edges)
                  next_r.state = ST_IDLE;
            end
            // A controller that stops the strobe early must not hang us.
            if (lnk.ck_rise)
            begin
               next_r.post_ck = r.post_ck + 2'h1;
               if (r.post_ck + 2'h1 == `DBW_WPST_CK_LIMIT)
                  next_r.state = ST_IDLE;
            end
         end

         // Illegal one-hot codes fall back to idle.
         default:
         begin
            next_r.state = ST_IDLE;
         end
      endcase
   end

   // Single register bank for all sequencer state.
   // The reset is synchronous, so the whole struct stays in one clock
   // domain and leaves reset in the same cycle as the synchroniser.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         r       <= '0;
         r.state <= ST_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   // Outputs come straight from flip-flops. The two levels at the end are
   // decoded from the one-hot state register, so they change only at a
   // clock edge and carry no glitches.
   assign burst_start     = r.burst_start;
   assign burst_column    = r.column;
   assign beat_valid      = r.beat_valid;
   assign beat_data       = r.beat_data;
   assign beat_index      = r.beat_index;
   assign burst_last      = r.burst_last;
   assign recovery_start  = r.rec_start;
   assign align_error     = r.align_err;
   assign preamble_window = (r.state == ST_PREAMBLE);
   assign busy            = (r.state != ST_IDLE);

endmodule : dbw_write_path

/* File: include/dbw_defines.svh */
// Constants for the write-burst data path: encodings, fields and counts.
`ifndef DBW_DEFINES_SVH
`define DBW_DEFINES_SVH

// Width of the bundle of sampled pins: ck, cs, ca[5:0], strobe, dq[7:0].
`define DBW_PIN_W          17
`define DBW_PIN_CK         16
`define DBW_PIN_CS         15
`define DBW_PIN_CA_HI      14
`define DBW_PIN_CA_LO      9
`define DBW_PIN_STRB       8
`define DBW_PIN_DQ_HI      7

// Command encodings on ca[4:0]; ca[5] carries an address bit.
`define DBW_CMD_WRITE1     5'h04
`define DBW_CMD_CAS2       5'h12

// Mode register addresses and bit positions inside the operand.
`define DBW_MR_BL_ADDR     6'h01
`define DBW_MR_BL_BIT      0
`define DBW_MR_WL_ADDR     6'h02
`define DBW_MR_WL_IDX_HI   5
`define DBW_MR_WL_IDX_LO   3
`define DBW_MR_WL_SET_BIT  6
`define DBW_MR_PST_ADDR    6'h03
`define DBW_MR_PST_BIT     1

// Write latency tables in clocks, entry 0 in the low six bits.
`define DBW_WL_SET_A  {6'h12, 6'h10, 6'h0e, 6'h0c, 6'h0a, 6'h08, 6'h06, 6'h04}
`define DBW_WL_SET_B  {6'h22, 6'h1e, 6'h1a, 6'h16, 6'h12, 6'h0c, 6'h08, 6'h04}

// Preamble length in command clocks.
`define DBW_WPRE_NCK       6'h02
// Postamble length in strobe half periods (0.5 and 1.5 clocks).
`define DBW_WPST_HALF_STD  2'h1
`define DBW_WPST_HALF_EXT  2'h3
// Command clocks after which the postamble is given up if the strobe stops.
`define DBW_WPST_CK_LIMIT  2'h3
// Index of the last beat for 16- and 32-beat bursts.
`define DBW_BEAT_LAST_16   5'h0f
`define DBW_BEAT_LAST_32   5'h1f

`endif

/* File: include/dbw_link_if.sv */
// Carrier between the pin synchroniser, the mode registers and the core.
`timescale 1ns/1ps
interface dbw_link_if;
   logic       ck_rise;    // Command clock rose (one sys_clk pulse).
   logic       strb_rise;  // True strobe rose.
   logic       strb_fall;  // True strobe fell.
   logic       cs;         // Chip select, aligned with ck_rise.
   logic [5:0] ca;         // Command/address lines, aligned with ck_rise.
   logic [7:0] dq;         // Data lines, aligned with the strobe edges.
   logic [5:0] wl_value;   // Write latency in clocks.
   logic       post_ext;   // Extended postamble selected.
   logic       bl32;       // 32-beat bursts selected.

   modport sync (output ck_rise, strb_rise, strb_fall, cs, ca, dq);
   modport mode (output wl_value, post_ext, bl32);
   modport core (input ck_rise, strb_rise, strb_fall, cs, ca, dq,
                 input wl_value, post_ext, bl32);
endinterface : dbw_link_if

/* File: include/dbw_pkg.sv */
// Types shared by the write-burst data path modules.
package dbw_pkg;

   // One-hot states of the burst sequencer.
   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_CAS      = 7'h02,
      ST_LATENCY  = 7'h04,
      ST_PREAMBLE = 7'h08,
      ST_ARMED    = 7'h10,
      ST_CAPTURE  = 7'h20,
      ST_POST     = 7'h40
   } dbw_state_t;

   // State of the pin synchroniser.
   typedef struct packed {
      logic [16:0] s1;
      logic [16:0] s2;
      logic        ck3;
      logic        strb3;
   } dbw_sync_t;

   // Mode register fields that steer the burst.
   typedef struct packed {
      logic [2:0] wl_idx;
      logic       wl_setb;
      logic       post_ext;
      logic       bl32;
   } dbw_mode_t;

   // State of the burst sequencer, outputs included.
   typedef struct packed {
      dbw_state_t  state;
      logic [5:0]  lat_cnt;
      logic [4:0]  beat_cnt;
      logic [1:0]  post_cnt;
      logic [1:0]  post_ck;
      logic [5:0]  wl;
      logic        bl32;
      logic        ext;
      logic        rec_pend;
      logic [9:0]  column;
      logic        burst_start;
      logic        beat_valid;
      logic [7:0]  beat_data;
      logic [4:0]  beat_index;
      logic        burst_last;
      logic        rec_start;
      logic        align_err;
   } dbw_core_t;

endpackage : dbw_pkg

/* File: tb/dbw_host_model.sv */
// Memory controller model that plays write bursts onto the device pins.
`timescale 1ns/1ps
module dbw_host_model
(
   output logic       ck_pin,
   output logic       cs_pin,
   output logic [5:0] ca_pin,
   output logic       strb_t_pin,
   output logic [7:0] dq_pin
);
   // All lines rest low between frames: they are terminated to ground.
   initial
   begin
      ck_pin = 1'h0;
      cs_pin = 1'h0;
      ca_pin = 6'h00;
      strb_t_pin = 1'h0;
      dq_pin = 8'h00;
   end

   // One frame on a grid of quarter clocks (20 ns); ck rises at q = 4m+2.
   // Beat 0 rises 0.75 clock after the latency edge, so it can never
   // be mistaken for the edge that arms the capture.
   // A cut frame stops the strobe after the last beat: no postamble.
   task automatic write_burst(input logic [4:0] cmd, input logic col3,
                              input int wl, input logic bl32,
                              input logic ext, input logic cut,
                              input logic [7:0] base);
      int q_b;
      int last;
      int q_last;
      int n;
      q_b = 6 + 4 * wl + 3;
      last = bl32 ? 31 : 15;
      q_last = q_b + 2 * (last + (ext ? 3 : 1));
      for (int q = 0; q <= q_last + 12; q++)
      begin
         ck_pin = (q % 4 == 2) ? 1'h1 : (q % 4 == 0) ? 1'h0 : ck_pin;
         // no precharge or read is ever sent
         cs_pin = (q < 8);
         ca_pin = (q < 4) ? {col3, cmd} : (q < 8) ? 6'h12 : 6'h00;
         if (q < q_b - 8)
            strb_t_pin = ~strb_t_pin;
         else if (q < q_b - 4 || q >= q_last + 2 ||
                  (cut && q > q_b + 2 * last))
            strb_t_pin = 1'h0;
         else
            strb_t_pin = ((q - q_b + 4) % 4) < 2;
         n = (q - q_b + 1) / 2;
         if (q >= q_b - 1 && n <= last)
            dq_pin = base + 8'(n);
         else
            dq_pin = (q < q_b) ? ~dq_pin : 8'h00;
         #20;
      end
      ck_pin = 1'h0;
   endtask : write_burst
endmodule : dbw_host_model

/* File: tb/dbw_write_path_checker.sv */
// Assertions on the ports of the write-burst data path.
`timescale 1ns/1ps
module dbw_write_path_checker
(
   input logic       sys_clk,
   input logic       rst,
   input logic       burst_start,
   input logic [9:0] burst_column,
   input logic       beat_valid,
   input logic [4:0] beat_index,
   input logic       burst_last,
   input logic       recovery_start,
   input logic       preamble_window,
   input logic       busy
);
   logic [4:0] prev_idx; // Index of the previous beat.

   // Keep the last beat so the next one can be compared with it.
   always_ff @(posedge sys_clk)
      if (rst)
         prev_idx <= 5'h00;
      else if (beat_valid)
         prev_idx <= beat_index;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_column_aligned: assert property (burst_column[3:0] == 4'h0)
      else $error("burst column not aligned");
   a_start_idle: assert property (
      burst_start |-> $past(busy) && busy ##1 !burst_start)
      else $error("burst start without command");
   a_beat_armed: assert property (
      beat_valid |-> busy && !preamble_window)
      else $error("beat outside armed burst");
   a_index_step: assert property (
      beat_valid && beat_index != 5'h00 |-> beat_index == prev_idx + 5'h01)
      else $error("beat index skipped");
   a_last_index: assert property (burst_last |-> beat_valid &&
      (beat_index == 5'h0f || beat_index == 5'h1f))
      else $error("last beat index wrong");
   a_preamble_len: assert property ($rose(preamble_window) |=>
      preamble_window[*8] ##23 preamble_window ##1 !preamble_window)
      else $error("preamble window not two clocks");
   a_recovery_soon: assert property (
      burst_last |-> ##[1:20] recovery_start)
      else $error("recovery start missing");
   a_post_quiet: assert property (recovery_start |=> !beat_valid[*8])
      else $error("postamble edge taken as beat");
endmodule : dbw_write_path_checker

bind dbw_write_path dbw_write_path_checker u_dbw_write_path_checker (
   .sys_clk(sys_clk), .rst(rst), .burst_start(burst_start),
   .burst_column(burst_column), .beat_valid(beat_valid),
   .beat_index(beat_index), .burst_last(burst_last),
   .recovery_start(recovery_start), .preamble_window(preamble_window),
   .busy(busy));

/* File: tb/test_dbw_write_path.sv */
// Self-checking bench for the write-burst data path.
`timescale 1ns/1ps
module test_dbw_write_path import dbw_pkg::*;;
   logic       sys_clk, rst, ck_pin, cs_pin, strb_t_pin, mrw_valid;
   logic [5:0] ca_pin, mrw_addr;
   logic [7:0] dq_pin, mrw_op, beat_data;
   logic [9:0] burst_column;
   logic [4:0] beat_index;
   logic       burst_start, beat_valid, burst_last, recovery_start;
   logic       align_error, preamble_window, busy, pw_q, busy_q, cut;
   int         n_mismatch, total_checks, cyc, n_start, n_beat, n_rec;
   int         n_align, last_at, t_start, t_pw, t_last, t_idle;
   logic [7:0] got_d [32]; // Data of each beat seen.
   logic [4:0] got_i [32]; // Index of each beat seen.

   // One burst setting beside the latency it must give.
   typedef struct packed {
      logic       setb;
      logic [2:0] idx;
      logic       bl32;
      logic       ext;
      logic       col3;
      logic [5:0] wl;
   } dbw_row_t;
   dbw_row_t rows [6] = '{{1'h0, 3'h0, 1'h0, 1'h0, 1'h0, 6'h04},
      {1'h0, 3'h7, 1'h1, 1'h1, 1'h0, 6'h12},
      {1'h1, 3'h7, 1'h0, 1'h1, 1'h0, 6'h22},
      {1'h1, 3'h3, 1'h1, 1'h0, 1'h1, 6'h12},
      {1'h0, 3'h2, 1'h0, 1'h1, 1'h0, 6'h08},
      {1'h1, 3'h1, 1'h0, 1'h0, 1'h0, 6'h08}};

   dbw_write_path u_dbw_write_path (.sys_clk(sys_clk), .rst(rst),
      .ck_pin(ck_pin), .cs_pin(cs_pin), .ca_pin(ca_pin),
      .strb_t_pin(strb_t_pin), .dq_pin(dq_pin), .mrw_valid(mrw_valid),
      .mrw_addr(mrw_addr), .mrw_op(mrw_op), .burst_start(burst_start),
      .burst_column(burst_column), .beat_valid(beat_valid),
      .beat_data(beat_data), .beat_index(beat_index),
      .burst_last(burst_last), .recovery_start(recovery_start),
      .align_error(align_error), .preamble_window(preamble_window),
      .busy(busy));
   dbw_host_model u_dbw_host_model (.ck_pin(ck_pin), .cs_pin(cs_pin),
      .ca_pin(ca_pin), .strb_t_pin(strb_t_pin), .dq_pin(dq_pin));

   // The 200 MHz system clock.
   initial
   begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      if (n_mismatch == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [31:0] got,
                        input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   // Record what the device reports at the falling edge, half a cycle
   // after its flops moved; a hang is cut short here too.
   always @(negedge sys_clk)
   begin
      cyc++;
      t_start = (burst_start === 1'h1) ? cyc : t_start;
      t_pw = (preamble_window === 1'h1 && pw_q === 1'h0) ? cyc : t_pw;
      t_idle = (busy === 1'h0 && busy_q === 1'h1) ? cyc : t_idle;
      t_last = (burst_last === 1'h1) ? cyc : t_last;
      last_at = (burst_last === 1'h1) ? n_beat : last_at;
      if (beat_valid === 1'h1 && n_beat < 32)
      begin
         got_i[n_beat] = beat_index;
         got_d[n_beat] = beat_data;
      end
      n_beat += (beat_valid === 1'h1);
      n_start += (burst_start === 1'h1);
      n_rec += (recovery_start === 1'h1);
      n_align += (align_error === 1'h1);
      pw_q = preamble_window;
      busy_q = busy;
      if (cyc == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic mode_write(input logic [5:0] a, input logic [7:0] op);
      @(negedge sys_clk);
      mrw_valid = 1'h1;
      mrw_addr = a;
      mrw_op = op;
      @(negedge sys_clk);
      mrw_valid = 1'h0;
   endtask : mode_write

   // Reset is held 16 cycles; the outputs must be quiet at its last cycle.
   task automatic do_reset();
      @(negedge sys_clk);
      rst = 1'h1;
      repeat (16) @(negedge sys_clk);
      check("idle", {busy, preamble_window, beat_valid, burst_start},
            0);
      rst = 1'h0;
   endtask : do_reset

   task automatic run_case(input dbw_row_t r, input logic modes,
                           input logic [4:0] cmd, input logic [7:0] base);
      int last;
      last = r.bl32 ? 31 : 15;
      if (modes)
      begin
         mode_write(6'h01, {7'h00, r.bl32});
         mode_write(6'h02, {1'h0, r.setb, r.idx, 3'h0});
         mode_write(6'h03, {6'h00, r.ext, 1'h0});
      end
      @(negedge sys_clk);
      n_start = 0;
      n_beat = 0;
      n_rec = 0;
      n_align = 0;
      u_dbw_host_model.write_burst(cmd, r.col3, int'(r.wl), r.bl32, r.ext,
                                   cut, base);
      for (int i = 0; i < 400 && busy !== 1'h0; i++)
         @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      if (cmd !== 5'h04)
      begin
         check("dropped", n_start + n_beat, 0);
         return;
      end
      check("start", n_start, 1);
      check("align", n_align, r.col3);
      // The column half carries ca 12, the top six column bits.
      check("column", burst_column, 10'h120);
      check("latency", t_pw - t_start, (int'(r.wl) - 2) * 16);
      check("beats", n_beat, last + 1);
      check("last", last_at, last);
      check("recovery", n_rec, 1);
      // A cut strobe waits for the third clock rise: 12 cycles + 2 x 16.
      check("postamble", t_idle - t_last, cut ? 44 : r.ext ? 24 : 8);
      for (int n = 0; n <= last; n++)
      begin
         check("index", got_i[n], n);
         check("data", got_d[n], base + n);
      end
   endtask : run_case

   // Reset defaults, the table, then an ignored write, a bad command
   // and a second reset that must restore the defaults.
   initial
   begin
      rst = 1'h1;
      mrw_valid = 1'h0;
      mrw_addr = 6'h00;
      mrw_op = 8'h00;
      cut = 1'h0;
      do_reset();
      run_case(rows[0], 1'h0, 5'h04, 8'h11);
      foreach (rows[i])
         run_case(rows[i], 1'h1, 5'h04, 8'(i * 32));
      mode_write(6'h05, 8'hff);
      run_case(rows[5], 1'h0, 5'h04, 8'hc0);
      run_case(rows[5], 1'h0, 5'h05, 8'h00);
      cut = 1'h1;
      run_case(rows[0], 1'h1, 5'h04, 8'h80);
      cut = 1'h0;
      mode_write(6'h02, 8'h78);
      do_reset();
      run_case(rows[0], 1'h0, 5'h04, 8'h40);
      give_verdict();
   end
endmodule : test_dbw_write_path
